/* design/fspc_map.svh */
// register offsets, field positions, reset values and timing counts of the flash self-program control
`ifndef FSPC_MAP_SVH
`define FSPC_MAP_SVH

// register address on the plain register port
`define FSPC_CSR_ADDR 6'h37
`define FSPC_CSR_RESET 8'h00

// control/status field positions
`define FSPC_B_IRQ_EN 7
`define FSPC_B_BUSY 6
`define FSPC_B_SIG 5
`define FSPC_B_RSRE 4
`define FSPC_B_LOCK 3
`define FSPC_B_PGW 2
`define FSPC_B_PGE 1
`define FSPC_B_SEN 0

// the only accepted patterns of the low six control bits
`define FSPC_PAT_SIG 6'h21
`define FSPC_PAT_RSRE 6'h11
`define FSPC_PAT_LOCK 6'h09
`define FSPC_PAT_PGW 6'h05
`define FSPC_PAT_PGE 6'h03
`define FSPC_PAT_LOAD 6'h01

// command windows in cpu cycles
`define FSPC_STORE_WIN 3'h4
`define FSPC_LOAD_WIN 3'h3

// pointer layout: byte bit, word in page, page index
`define FSPC_WORD_LSB 1
`define FSPC_WORD_W 6
`define FSPC_PAGE_LSB 7
`define FSPC_PAGE_W 9
`define FSPC_PAGE_WORDS 64

// pages below this index form the read-while-write section
`define FSPC_RWW_PAGE_LIMIT 9'h100

// value of a buffer word that was never loaded (erased flash)
`define FSPC_BUF_BLANK 16'hffff

`endif

/* design/fspc_pkg.sv */
// types shared by the flash self-program control and its page buffer
package fspc_pkg;

  // sequencer state, gray along idle -> armed -> busy
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ARMED = 2'h1,
    ST_BUSY = 2'h3
  } fspc_state_t;

  // kind of long flash operation handed to the array
  typedef enum logic [1:0] {
    FOP_ERASE = 2'h0,
    FOP_WRITE = 2'h1,
    FOP_LOCK = 2'h2
  } fspc_fop_t;

  // one cpu cycle of store/load program memory instruction traffic
  typedef struct packed {
    logic store_prog_instr; // store instruction executes this cycle
    logic load_instr;       // load instruction executes this cycle
    logic [15:0] zptr;      // pointer register
    logic [15:0] r1r0;      // data word r0
  } fspc_cpu_req_t;

  // request to the flash array
  typedef struct packed {
    logic start;            // one-cycle launch pulse
    fspc_fop_t kind;        // erase, write or lock program
    logic [8:0] page;       // latched page index
    logic [7:0] lock_data;  // lock bits from r0
  } fspc_flash_op_t;

endpackage

/* design/fspc_page_buf.sv */
// temporary page buffer: one word per page slot, loaded once between clears
`timescale 1ns/1ps
`include "fspc_map.svh"
module fspc_page_buf (
  input wire logic clk,                        // system clock
  input wire logic rst,                        // async reset, active high
  input wire logic clr,                        // wipe all loaded words
  input wire logic wr,                         // load one word
  input wire logic [`FSPC_WORD_W-1:0] wr_idx,  // word in page
  input wire logic [15:0] wr_data,             // word r0
  input wire logic [`FSPC_WORD_W-1:0] rd_idx,  // read index from flash array
  output logic [15:0] rd_data                  // registered read word
);
  import fspc_pkg::*;

  logic [15:0] mem [`FSPC_PAGE_WORDS];
  logic [`FSPC_PAGE_WORDS-1:0] loaded_reg;
  wire rd_loaded = loaded_reg[rd_idx];

  // a slot already loaded is kept: a second load would corrupt it anyway
  genvar gi;
  generate
    for (gi = 0; gi < `FSPC_PAGE_WORDS; gi++) begin : g_slot
      wire hit = wr && !clr && (wr_idx == gi) && !loaded_reg[gi];
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          loaded_reg[gi] <= 1'b0;
        end else if (clr) begin
          loaded_reg[gi] <= 1'b0;
        end else if (hit) begin
          loaded_reg[gi] <= 1'b1;
        end
      end
      always_ff @(posedge clk) begin
        if (hit) begin
          mem[gi] <= wr_data;
        end
      end
    end
  endgenerate

  // unloaded slots read as blank so a cleared buffer never leaks old data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= `FSPC_BUF_BLANK;
    end else begin
      rd_data <= rd_loaded ? mem[rd_idx] : `FSPC_BUF_BLANK;
    end
  end
endmodule

/* design/fspc_ctrl.sv */
// flash self-program control: control/status register, command windows and flash sequencing
// How it works
// - ready interrupt requested while enable, global flag set and store enable clear.
// - erase/write of a read-while-write page sets busy; that section then unreadable.
// - busy clears on read-enable command after programming, or on buffer load.
// - signature mode: load within three cycles returns signature byte; store does nothing.
// - read-enable mode: store within four cycles re-enables section; refused while an erase, write or lock program runs.
// - writing read-enable bit during buffer load aborts load and drops data.
// - lock mode: store within four cycles programs lock bits from r0; else self-clears.
// - lock mode load within three cycles returns lock or fuse bits by pointer bits 1:0.
// - page write: store within four cycles programs buffer into pointer page; self-clears.
// - page erase: store within four cycles erases pointer page; self-clears.
// - no-read-while-write target halts cpu; read-while-write target keeps fetching.
// - store enable alone: store loads r0 into buffer at pointer word field.
// - store enable clears after store or four idle cycles; held during erase/write.
// - only the six listed low-bit patterns take effect; others ignored.
// - target page latched at operation start; pointer free afterwards.
// - loads use pointer bit0 bytewise; lock set ignores pointer entirely.
// - buffer clears after page write, on read-enable write, and on reset.
`timescale 1ns/1ps
`include "fspc_map.svh"
module fspc_ctrl (
  input wire logic clk,                           // system clock, 200 MHz
  input wire logic rst,                           // async reset, active high
  input wire logic [5:0] reg_addr,                // register address
  input wire logic [7:0] reg_wdata,               // register write data
  input wire logic reg_wr,                        // write strobe
  input wire logic reg_rd,                        // read strobe
  output logic [7:0] reg_rdata,                   // read data, cycle after strobe
  input wire logic gie,                           // cpu global interrupt flag
  input wire fspc_pkg::fspc_cpu_req_t cpu,        // instruction traffic
  output logic lpm_special,                       // load answered by this block
  output logic [7:0] lpm_data,                    // byte for the load
  output logic [4:0] sig_addr,                    // signature row address
  input wire logic [7:0] sig_byte,                // signature row byte
  input wire logic [7:0] lock_bits,               // current lock bits
  input wire logic [7:0] fuse_low,                // fuse low byte
  input wire logic [7:0] fuse_high,               // fuse high byte
  output fspc_pkg::fspc_flash_op_t flash_op,      // launch to flash array
  input wire logic flash_done,                    // array finished operation
  input wire logic [`FSPC_WORD_W-1:0] buf_rd_idx, // array reads buffer slot
  output logic [15:0] buf_rd_word,                // buffer slot, one cycle later
  output logic irq_req,                           // ready interrupt request
  output logic cpu_halt,                          // stall cpu during no-read-while-write erase/write
  output logic rww_read_block                     // section busy, no fetch
);
  import fspc_pkg::*;

  // state and held command pattern
  fspc_state_t state_reg, state_next;
  logic [5:0] cmd_reg, cmd_next;

  // software interrupt enable
  logic irq_en_reg;

  // section busy, hardware owned
  logic busy_reg, busy_next;

  // store and load windows
  logic [2:0] store_cnt_reg, store_cnt_next;
  logic [2:0] load_cnt_reg, load_cnt_next;

  // target latched at launch
  logic [8:0] page_reg, page_next;
  fspc_fop_t kind_reg, kind_next;
  logic no_read_while_write_section_reg, no_read_while_write_section_next;
  logic [7:0] lockd_reg, lockd_next;

  // launch request
  logic start_next;

  // page buffer strobes
  logic buf_clr, buf_wr;

  // register port decode
  // one mapped address; others ignored, read as zero
  wire csr_wr = reg_wr && (reg_addr == `FSPC_CSR_ADDR);
  wire csr_rd = reg_rd && (reg_addr == `FSPC_CSR_ADDR);
  wire [5:0] wpat = reg_wdata[5:0];

  // command pattern check; anything else leaves the low bits alone
  // a refused pattern still writes the interrupt enable
  wire pat_ok = (wpat == `FSPC_PAT_SIG)
    || (wpat == `FSPC_PAT_RSRE)
    || (wpat == `FSPC_PAT_LOCK)
    || (wpat == `FSPC_PAT_PGW)
    || (wpat == `FSPC_PAT_PGE)
    || (wpat == `FSPC_PAT_LOAD);

  // no new command while an erase, write or lock program runs
  // so a re-enable cannot slip in mid-operation
  wire op_running = (state_reg == ST_BUSY);
  wire cmd_take = csr_wr && pat_ok && !op_running;

  // armed-mode decode of the held pattern
  // at most one mode is true: the held pattern is one of six
  wire armed = (state_reg == ST_ARMED);
  wire m_sig = armed && (cmd_reg == `FSPC_PAT_SIG);
  wire m_rsre = armed && (cmd_reg == `FSPC_PAT_RSRE);
  wire m_lock = armed && (cmd_reg == `FSPC_PAT_LOCK);
  wire m_pgw = armed && (cmd_reg == `FSPC_PAT_PGW);
  wire m_pge = armed && (cmd_reg == `FSPC_PAT_PGE);
  wire m_load = armed && (cmd_reg == `FSPC_PAT_LOAD);

  // windows: store in the four cycles after the write, load in the first three
  // a count of one is the last cycle a store is taken
  wire store_open = armed && (store_cnt_reg != 3'h0);
  wire load_open = armed && (load_cnt_reg != 3'h0);
  wire store_hit = store_open && cpu.store_prog_instr;
  wire load_hit = load_open && cpu.load_instr && (m_sig || m_lock);
  wire store_timeout = armed && (store_cnt_reg == 3'h1) && !store_hit;

  // pointer fields
  // stores ignore the byte bit; loads use it
  wire [8:0] z_page = cpu.zptr[`FSPC_PAGE_LSB +: `FSPC_PAGE_W];
  wire [`FSPC_WORD_W-1:0] z_word = cpu.zptr[`FSPC_WORD_LSB +: `FSPC_WORD_W];
  // pages below the limit form the read-while-write section
  wire z_rww = (z_page < `FSPC_RWW_PAGE_LIMIT);

  // byte for a special load: lock/fuse by pointer bit0, else signature
  // bit1 matters only with bit0 set
  wire [7:0] odd_byte = cpu.zptr[1] ? fuse_high : lock_bits;
  wire [7:0] lf_byte = cpu.zptr[0] ? odd_byte : fuse_low;
  wire [7:0] special_byte = m_sig ? sig_byte : lf_byte;
  assign sig_addr = cpu.zptr[4:0];

  // long operation finishing this cycle
  // a done pulse outside an operation is ignored
  wire op_done = op_running && flash_done;

  // buffer write and clear strobes; a same-cycle command write drops the store
  assign buf_wr = store_hit && m_load && !cmd_take;
  assign buf_clr = (cmd_take && wpat[`FSPC_B_RSRE])
    || (op_done && (kind_reg == FOP_WRITE));

  // sequencer next state
  // defaults hold everything; branches change what they own
  always_comb begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    store_cnt_next = store_cnt_reg;
    load_cnt_next = load_cnt_reg;
    page_next = page_reg;
    kind_next = kind_reg;
    no_read_while_write_section_next = no_read_while_write_section_reg;
    lockd_next = lockd_reg;
    start_next = 1'b0;

    unique case (state_reg)
      ST_IDLE: begin
        // windows stay shut until a valid command write
        store_cnt_next = 3'h0;
        load_cnt_next = 3'h0;
      end
      ST_ARMED: begin
        // both windows shrink every armed cycle
        store_cnt_next = (store_cnt_reg != 3'h0) ? store_cnt_reg - 3'h1 : 3'h0;
        load_cnt_next = (load_cnt_reg != 3'h0) ? load_cnt_reg - 3'h1 : 3'h0;
        if (store_hit && (m_pge || m_pgw)) begin
          // latch the target so software may reuse the pointer
          page_next = z_page;
          no_read_while_write_section_next = !z_rww;
          kind_next = m_pgw ? FOP_WRITE : FOP_ERASE;
          start_next = 1'b1;
          state_next = ST_BUSY;
          store_cnt_next = 3'h0;
          load_cnt_next = 3'h0;
        end else if (store_hit && m_lock) begin
          // lock program takes r0 only; pointer and unused
          lockd_next = cpu.r1r0[7:0];
          page_next = 9'h000;
          no_read_while_write_section_next = 1'b0;
          kind_next = FOP_LOCK;
          start_next = 1'b1;
          state_next = ST_BUSY;
          store_cnt_next = 3'h0;
          load_cnt_next = 3'h0;
        end else if (store_hit || load_hit || store_timeout) begin
          // load, read-enable, ignored signature store, special load or expiry
          state_next = ST_IDLE;
          cmd_next = 6'h00;
          store_cnt_next = 3'h0;
          load_cnt_next = 3'h0;
        end
      end
      ST_BUSY: begin
        // windows stay shut while the array works
        if (flash_done) begin
          // self-clear of the command and store enable on completion
          state_next = ST_IDLE;
          cmd_next = 6'h00;
        end
      end
      default: begin
        // unused code: recover to idle, drop the command
        state_next = ST_IDLE;
        cmd_next = 6'h00;
      end
    endcase

    // a fresh command write restarts both windows
    if (cmd_take) begin
      state_next = ST_ARMED;
      cmd_next = wpat;
      store_cnt_next = `FSPC_STORE_WIN;
      load_cnt_next = `FSPC_LOAD_WIN;
      // the write beats a store in the same cycle: nothing launches
      start_next = 1'b0;
      page_next = page_reg;
      kind_next = kind_reg;
      no_read_while_write_section_next = no_read_while_write_section_reg;
      lockd_next = lockd_reg;
    end
  end

  // section busy: set on launch of an rww erase/write; set wins over any clear
  always_comb begin
    busy_next = busy_reg;
    // a clear needs an executed command; a same-cycle write wins
    if ((store_hit && m_rsre && !cmd_take) || buf_wr) begin
      busy_next = 1'b0;
    end

    if (start_next && (kind_next != FOP_LOCK) && !no_read_while_write_section_next) begin
      busy_next = 1'b1;
    end
  end

  // sequencer registers
  // counters reset shut, so no store is taken
  // before the first command write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cmd_reg <= 6'h00;
      store_cnt_reg <= 3'h0;
      load_cnt_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      store_cnt_reg <= store_cnt_next;
      load_cnt_reg <= load_cnt_next;
    end
  end

  // latched operation target
  // changed only at launch, held for the operation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      page_reg <= 9'h000;
      kind_reg <= FOP_ERASE;
      no_read_while_write_section_reg <= 1'b0;
      lockd_reg <= 8'h00;
    end else begin
      page_reg <= page_next;
      kind_reg <= kind_next;
      no_read_while_write_section_reg <= no_read_while_write_section_next;
      lockd_reg <= lockd_next;
    end
  end

  // interrupt enable is written on every register write, valid pattern or not
  // busy is read-only: a register write never touches it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_en_reg <= 1'(`FSPC_CSR_RESET >> `FSPC_B_IRQ_EN);
      busy_reg <= 1'b0;
    end else begin
      if (csr_wr) begin
        irq_en_reg <= reg_wdata[`FSPC_B_IRQ_EN];
      end
      busy_reg <= busy_next;
    end
  end

  // launch pulse and target to the flash array
  // fields hold until the next launch,
  // so the array may sample them late
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_op <= '0;
    end else begin
      flash_op.start <= start_next;
      if (start_next) begin
        flash_op.kind <= kind_next;
        flash_op.page <= page_next;
        flash_op.lock_data <= lockd_next;
      end
    end
  end

  // special load answer, one cycle after the load instruction
  // data keeps the last answer;
  // only lpm_special marks a fresh one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lpm_special <= 1'b0;
      lpm_data <= 8'h00;
    end else begin
      lpm_special <= load_hit;
      if (load_hit) begin
        lpm_data <= special_byte;
      end
    end
  end

  // register read: busy bit is hardware state; unmapped addresses read zero
  // a read has no side effect on any flag
  wire [7:0] csr_view = {irq_en_reg, busy_reg, cmd_reg};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= csr_rd ? csr_view : 8'h00;
    end
  end

  // cpu-facing status; halt only for no-read-while-write erase/write
  // irq drops the cycle after a command is armed
  assign irq_req = irq_en_reg && gie && !cmd_reg[`FSPC_B_SEN];
  assign cpu_halt = op_running && no_read_while_write_section_reg && (kind_reg != FOP_LOCK);
  assign rww_read_block = busy_reg;

  // temporary page buffer
  // the array reads slots itself; software cannot
  fspc_page_buf u_buf (
    .clk(clk),
    .rst(rst),
    .clr(buf_clr),
    .wr(buf_wr),
    .wr_idx(z_word),
    .wr_data(cpu.r1r0),
    .rd_idx(buf_rd_idx),
    .rd_data(buf_rd_word)
  );
endmodule

/* dv/fspc_flash_model.sv */
// flash array stand-in: ends each launched op after a prompt or a long delay
`timescale 1ns/1ps
module fspc_flash_model #(
  parameter int DLY = 20 // cycles of a prompt op
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset
  input wire fspc_pkg::fspc_flash_op_t op, // launch from controller
  input wire logic slow, // triple the op time
  output logic done // one-cycle end pulse
);
  import fspc_pkg::*;
  int cnt;
  // count down from launch; a relaunch mid-op restarts the count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      done <= 1'b0;
    end else begin
      done <= cnt == 1;
      if (op.start) begin
        cnt <= slow ? 3 * DLY : DLY;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

/* dv/fspc_ctrl_monitor.sv */
// port assertions for the flash self-program control
`timescale 1ns/1ps
`include "fspc_map.svh"
module fspc_ctrl_monitor (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic [5:0] reg_addr, // address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic gie, // global irq flag
  input wire fspc_pkg::fspc_cpu_req_t cpu, // instructions
  input wire logic lpm_special, // load answered
  input wire fspc_pkg::fspc_flash_op_t flash_op, // launch
  input wire logic flash_done, // op end
  input wire logic irq_req, // ready irq
  input wire logic cpu_halt, // cpu stall
  input wire logic rww_read_block // section busy
);
  import fspc_pkg::*;
  logic op_run, ien_seen;
  // shorthands for instruction and launch kinds
  wire st = cpu.store_prog_instr;
  wire ld = cpu.load_instr;
  wire go = flash_op.start && flash_op.kind != FOP_LOCK;
  wire low = flash_op.page < `FSPC_RWW_PAGE_LIMIT;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // commands are refused mid-op, so arming is only judged outside one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_run <= 1'b0;
    end else if (flash_op.start || flash_done) begin
      op_run <= flash_op.start;
    end
  end
  // interrupt enable as last written: bit 7 lands on every register write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ien_seen <= 1'b0;
    end else if (reg_wr && reg_addr == `FSPC_CSR_ADDR) begin
      ien_seen <= reg_wdata[`FSPC_B_IRQ_EN];
    end
  end
  sequence s_arm(logic [5:0] pat);
    reg_wr && reg_addr == `FSPC_CSR_ADDR && reg_wdata[5:0] == pat && !op_run && !flash_op.start;
  endsequence
  sequence s_cmd(logic [5:0] pat);
    s_arm(pat) ##[1:4] st;
  endsequence
  erase_launch_a: assert property (s_cmd(`FSPC_PAT_PGE) |=> go && flash_op.kind == FOP_ERASE
    && flash_op.page == $past(cpu.zptr[15:7])) else $error("erase not launched on pointer page");
  write_launch_a: assert property (s_cmd(`FSPC_PAT_PGW) |=> go && flash_op.kind == FOP_WRITE
    && flash_op.page == $past(cpu.zptr[15:7])) else $error("write not launched on pointer page");
  lock_launch_a: assert property (s_cmd(`FSPC_PAT_LOCK) |=> flash_op.start &&
    flash_op.lock_data == $past(cpu.r1r0[7:0])) else $error("lock program wrong");
  late_store_a: assert property (s_arm(`FSPC_PAT_PGE) ##1 (!st && !reg_wr)[*4] ##1 st
    |=> !flash_op.start) else $error("store after window accepted");
  lock_read_a: assert property (s_arm(`FSPC_PAT_LOCK) ##[1:3] ld |=> lpm_special)
    else $error("lock read not answered");
  rww_busy_a: assert property (go && low |-> rww_read_block && !cpu_halt)
    else $error("section busy wrong");
  no_read_while_write_section_halt_a: assert property (go && !low |-> cpu_halt)
    else $error("cpu not halted");
  irq_gate_a: assert property (irq_req |-> gie && ien_seen)
    else $error("irq without enable or global flag");
  irq_busy_a: assert property (go |-> !irq_req)
    else $error("irq during erase or write");
  irq_armed_a: assert property (s_arm(`FSPC_PAT_LOAD) |=> !irq_req)
    else $error("irq while store enable set");
endmodule
bind fspc_ctrl fspc_ctrl_monitor mon (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .gie(gie), .cpu(cpu), .lpm_special(lpm_special), .flash_op(flash_op),
  .flash_done(flash_done), .irq_req(irq_req), .cpu_halt(cpu_halt), .rww_read_block(rww_read_block));

/* dv/tb.sv */
// self-checking bench for the flash self-program control
`timescale 1ns/1ps
`include "fspc_map.svh"
module tb;
  import fspc_pkg::*;
  localparam logic [5:0] CSR = `FSPC_CSR_ADDR;
  logic clk, rst, reg_wr, reg_rd, gie, slow, lpm_special, flash_done, irq_req, cpu_halt, rww_read_block;
  logic [5:0] reg_addr, buf_rd_idx;
  logic [7:0] reg_wdata, reg_rdata, lpm_data, sig_byte, lock_bits, fuse_low, fuse_high;
  logic [4:0] sig_addr;
  logic [15:0] buf_rd_word;
  fspc_cpu_req_t cpu;
  fspc_flash_op_t flash_op;
  int err_total, tests_run, cycles;
  // signature row stand-in: byte follows its address
  assign sig_byte = {3'h5, sig_addr};
  fspc_ctrl dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gie(gie), .cpu(cpu), .lpm_special(lpm_special),
    .lpm_data(lpm_data), .sig_addr(sig_addr), .sig_byte(sig_byte), .lock_bits(lock_bits),
    .fuse_low(fuse_low), .fuse_high(fuse_high), .flash_op(flash_op), .flash_done(flash_done),
    .buf_rd_idx(buf_rd_idx), .buf_rd_word(buf_rd_word), .irq_req(irq_req), .cpu_halt(cpu_halt),
    .rww_read_block(rww_read_block));
  fspc_flash_model #(.DLY(20)) far (.clk(clk), .rst(rst), .op(flash_op), .slow(slow), .done(flash_done));
  // shared compare, bus and instruction tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("csr", {8'h00, exp}, {8'h00, reg_rdata});
  endtask
  task automatic op(input logic s, input logic l, input logic [15:0] z, input logic [15:0] d);
    @(posedge clk);
    cpu <= '{s, l, z, d};
    @(posedge clk);
    cpu <= '0;
    #1;
  endtask
  task automatic bufchk(input logic [5:0] i, input logic [15:0] exp);
    @(posedge clk);
    buf_rd_idx <= i;
    @(posedge clk);
    #1;
    chk("buffer word", exp, buf_rd_word);
  endtask
  task automatic wait_done();
    int n;
    for (n = 0; n < 200 && flash_done !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    chk("op end", 16'h1, {15'h0, n < 200});
  endtask
  // reset values, unmapped read, refused patterns and the ready irq
  task automatic t_regs();
    rd(CSR, 8'h00);
    rd(6'h10, 8'h00);
    bufchk(6'h00, 16'hffff);
    wr(CSR, 8'h87);
    rd(CSR, 8'h80);
    chk("irq", 16'h1, {15'h0, irq_req});
    wr(CSR, 8'h81);
    chk("irq", 16'h0, {15'h0, irq_req});
    repeat (4) @(posedge clk);
    #1;
    chk("irq", 16'h1, {15'h0, irq_req});
    @(posedge clk);
    gie <= 1'b0;
    #1;
    chk("irq", 16'h0, {15'h0, irq_req});
    wr(CSR, 8'h00);
  endtask
  // section busy, refused re-enable mid-op, cleared by load then by re-enable
  task automatic t_rww();
    for (int k = 0; k < 2; k++) begin
      wr(CSR, 8'h03);
      op(1'b1, 1'b0, {9'h010, 7'h00}, 16'h0000);
      chk("busy", 16'h1, {15'h0, rww_read_block});
      wr(CSR, 8'h11);
      rd(CSR, 8'h43);
      wait_done();
      rd(CSR, 8'h40);
      wr(CSR, k ? 8'h11 : 8'h01);
      op(1'b1, 1'b0, 16'h0000, 16'h0000);
      chk("busy", 16'h0, {15'h0, rww_read_block});
    end
  endtask
  // buffer load, then a re-enable write aborts a pending load
  task automatic t_load();
    wr(CSR, 8'h01);
    op(1'b1, 1'b0, 16'h000b, 16'ha55a);
    rd(CSR, 8'h00);
    bufchk(6'h05, 16'ha55a);
    wr(CSR, 8'h01);
    wr(CSR, 8'h11);
    op(1'b1, 1'b0, 16'h000c, 16'hbeef);
    bufchk(6'h06, 16'hffff);
    bufchk(6'h05, 16'hffff);
  endtask
  // erase then write one page of the halting section, second op slow
  task automatic t_no_read_while_write_section();
    wr(CSR, 8'h01);
    op(1'b1, 1'b0, {9'h1f0, 6'h02, 1'b1}, 16'h1234);
    bufchk(6'h02, 16'h1234);
    for (int k = 0; k < 2; k++) begin
      slow <= k[0];
      wr(CSR, k ? 8'h05 : 8'h03);
      op(1'b1, 1'b0, {9'h1f0, 7'h00}, 16'h0000);
      chk("halt", 16'h1, {15'h0, cpu_halt});
      wait_done();
      chk("halt", 16'h0, {15'h0, cpu_halt});
      chk("page", 16'h01f0, {7'h00, flash_op.page});
    end
    bufchk(6'h02, 16'hffff);
    rd(CSR, 8'h00);
  endtask
  // lock and fuse reads by pointer bits, lock program, plain load
  task automatic t_lock();
    logic [7:0] exp[3];
    exp = '{fuse_low, lock_bits, fuse_high};
    for (int i = 0; i < 3; i++) begin
      wr(CSR, 8'h09);
      op(1'b0, 1'b1, 16'(i + i / 2), 16'h0000);
      chk("special", 16'h1, {15'h0, lpm_special});
      chk("lock read", {8'h00, exp[i]}, {8'h00, lpm_data});
    end
    wr(CSR, 8'h09);
    op(1'b1, 1'b0, 16'h5a5a, 16'hffc3);
    wait_done();
    chk("lock data", 16'h00c3, {8'h00, flash_op.lock_data});
    rd(CSR, 8'h00);
    op(1'b0, 1'b1, 16'h0001, 16'h0000);
    chk("special", 16'h0, {15'h0, lpm_special});
  endtask
  // signature read, store in that mode, and the window edge
  task automatic t_sig_win();
    wr(CSR, 8'h21);
    op(1'b0, 1'b1, 16'h0007, 16'h0000);
    chk("signature", 16'h00a7, {8'h00, lpm_data});
    wr(CSR, 8'h21);
    op(1'b1, 1'b0, 16'h8000, 16'h0000);
    chk("launch", 16'h0, {15'h0, flash_op.start});
    for (int k = 2; k < 4; k++) begin
      wr(CSR, 8'h03);
      repeat (k) @(posedge clk);
      op(1'b1, 1'b0, {9'h1f4, 7'h00}, 16'h0000);
      chk("launch", {15'h0, k == 2}, {15'h0, flash_op.start});
      if (k == 2) begin
        wait_done();
      end
    end
    rd(CSR, 8'h00);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // hang guard, well beyond the few hundred cycles the run takes
  initial begin
    for (cycles = 0; cycles < 5000; cycles++) begin
      @(posedge clk);
    end
    err_total++;
    test_done();
  end
  initial begin
    {rst, gie, lock_bits, fuse_low, fuse_high} = {2'b11, 24'hc35ed9};
    {reg_wr, reg_rd, reg_addr, reg_wdata, buf_rd_idx, slow} = '0;
    cpu = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_rww();
    t_load();
    t_no_read_while_write_section();
    t_lock();
    t_sig_win();
    test_done();
  end
endmodule
